/* File: rtl/aip_pkg.sv */
// Purpose: shared constants for the accelerometer interrupt pin link
// Assumes: 10 MHz system clock on both ends, SPI mode 0 link
// Notes:   register offsets are the device's 7-bit register addresses
package aip_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ       = 10_000_000;
    localparam int BOOT_MIN_MS  = 20;
    localparam int BOOT_MAX_MS  = 50;
    localparam int SRST_MS      = 2;
    localparam int START_MIN_MS = 2;
    localparam int PULSE_US     = 50;
    localparam int BOOT_MIN_CYC = BOOT_MIN_MS * (CLK_HZ / 1000);
    localparam int BOOT_MAX_CYC = BOOT_MAX_MS * (CLK_HZ / 1000);
    localparam int SRST_CYC     = SRST_MS * (CLK_HZ / 1000);
    localparam int START_CYC    = START_MIN_MS * (CLK_HZ / 1000);
    localparam int PULSE_CYC    = PULSE_US * (CLK_HZ / 1_000_000);
    localparam int SPI_MAX_HZ   = 10_000_000;
    localparam int SCK_HALF     = 8;
    // ==========================================================
    // Device register addresses
    localparam logic [6:0] A_SRC2   = 7'h13;
    localparam logic [6:0] A_STATUS = 7'h15;
    localparam logic [6:0] A_REL    = 7'h17;
    localparam logic [6:0] A_CTL1   = 7'h18;
    localparam logic [6:0] A_CTL2   = 7'h19;
    localparam logic [6:0] A_PINC   = 7'h1c;
    localparam logic [6:0] A_WMASK  = 7'h1d;
    localparam logic [6:0] A_TMASK  = 7'h1e;
    localparam logic [6:0] A_TILTT  = 7'h22;
    localparam logic [6:0] A_WAKET  = 7'h23;
    localparam logic [6:0] A_TTH    = 7'h26;
    localparam logic [6:0] A_TTL    = 7'h27;
    localparam logic [6:0] A_FALL_THRESHOLD_REGISTER   = 7'h2c;
    localparam logic [6:0] A_FFC    = 7'h2d;
    localparam logic [6:0] A_FFCTL  = 7'h2e;
    // ==========================================================
    // Field positions
    localparam int B_OP    = 7;
    localparam int B_TAP_ENGINE_ENABLE  = 2;
    localparam int B_WAKE_ENGINE_ENABLE  = 1;
    localparam int B_TPE   = 0;
    localparam int B_SRST  = 7;
    localparam int B_LATCH = 3;
    localparam int B_POL   = 4;
    localparam int B_PEN   = 5;
    localparam int B_FALL_ENGINE_ENABLE  = 7;
    localparam int B_INT   = 4;
    localparam int B_VALID = 0;
    localparam int S_FALL  = 7;
    localparam int S_TAP   = 2;
    localparam int S_WAKE  = 1;
    localparam int S_TILT  = 0;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // ==========================================================
    // Host AXI4-Lite map
    localparam logic [3:0] H_CMD    = 4'h0;
    localparam logic [3:0] H_STATUS = 4'h4;
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    localparam int FRAME_BITS = 16;
endpackage : aip_pkg

/* File: rtl/aip_link_if.sv */
// Purpose: SPI link plus interrupt pin between host and device
// Assumes: miso is three-stated by the device while not selected
// Notes:   nothing reads miso_oe; the host samples the miso wire directly
`timescale 1ns/100ps
`default_nettype none
interface aip_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic int_pin;
    modport dev  (input sclk, cs_n, mosi, output miso, miso_oe, int_pin);
    modport host (output sclk, cs_n, mosi, input miso, miso_oe, int_pin);
endinterface : aip_link_if
`default_nettype wire

/* File: rtl/aip_device.sv */
// Purpose: accelerometer-side interrupt output, engines and SPI target
// Assumes: engine inputs and ticks come from the sensing datapath
// Notes:   frame = rw, 7-bit address, 8-bit data, msb first, mode 0
//
// How it works
// - latch mode holds pin until release
// - pulse mode gives one 50 us pulse
// - polarity bit sets idle and active level
// - pin enable bit gates the pin
// - release register read deasserts latched pin
// - release read clears sources and flag
// - boot takes 20 to 50 ms
// - ready 2 ms after soft reset
// - outputs valid after start-up delay
// - host waits two data periods entering operation
// - I2C rates up to 3.4 MHz; no I2C port here, only the SPI link is modelled
// - SPI clock up to 10 MHz
// - polling host reads flag, source, release
// - source register names engine until release
// - engines fire only when enabled
// - timers count own engine data rate
// - wake needs unmasked axis over timer
// - tilt, wake and tap masks honoured
// - tilt reports orientation stable until timer
// - fall debounce count before interrupt
// - tap jerk between low and high threshold
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module aip_device
    import aip_pkg::*;
#(
    parameter int BOOT_CYC  = BOOT_MIN_CYC,
    parameter int SRST_W    = SRST_CYC,
    parameter int START_W   = START_CYC
)(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    aip_link_if.dev         link,
    input  wire logic       tilt_tick,
    input  wire logic [5:0] tilt_orient,
    input  wire logic       wake_tick,
    input  wire logic [5:0] wake_over,
    input  wire logic       tap_tick,
    input  wire logic [7:0] tap_jerk,
    input  wire logic [5:0] tap_dir,
    input  wire logic       fall_tick,
    input  wire logic [7:0] fall_mag,
    output logic            accel_valid
);
    // ==========================================================
    // Pin synchronisers (sclk, cs_n, mosi)
    logic [2:0] s1;
    logic [2:0] s2;
    logic       sclk_d;
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            s1     <= 3'h4;
            s2     <= 3'h4;
            sclk_d <= 1'b0;
        end
        else if (ce)
        begin
            s1     <= {link.cs_n, link.sclk, link.mosi};
            s2     <= s1;
            sclk_d <= s2[1];
        end
    wire cs_act = !s2[2];
    wire rise   = cs_act && s2[1] && !sclk_d;
    wire fall   = cs_act && !s2[1] && sclk_d;

    // ==========================================================
    // Registers
    logic [7:0] ctl1, ctl2, pinc, wmask, tmask, tiltt, waket;
    logic [7:0] tap_high_threshold, ttl, fall_threshold_register, ffc, ffctl, src2;
    logic [24:0] busy_cnt;
    logic [21:0] start_cnt;
    logic [3:0]  bcnt;
    logic [14:0] rx;
    logic [7:0]  tx;
    logic        rd_rel;
    logic        srst_req;
    wire ready = (busy_cnt == '0);
    wire [15:0] frame = {rx, s2[0]};
    wire        wr_done = rise && ready && bcnt == 4'd15 && !rx[14];

    // Boot then soft reset wait; frames ignored until it ends
    always_ff @(posedge aclk)
        if (!aresetn)
            busy_cnt <= 25'(BOOT_CYC);
        else if (ce)
        begin
            if (srst_req)
                busy_cnt <= 25'(SRST_W);
            else if (!ready)
                busy_cnt <= busy_cnt - 25'd1;
        end

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            bcnt <= '0;
            rx   <= '0;
        end
        else if (ce)
        begin
            if (!cs_act)
                bcnt <= '0;
            else if (rise)
            begin
                rx   <= {rx[13:0], s2[0]};
                bcnt <= bcnt + 4'd1;
            end
        end

    function automatic logic [7:0] rd_mux(input logic [6:0] a);
        unique case (a)
            A_SRC2:   rd_mux = src2;
            A_STATUS: rd_mux = {3'h0, |src2, 3'h0, accel_valid};
            A_REL:    rd_mux = RST_ZERO;
            A_CTL1:   rd_mux = ctl1;
            A_CTL2:   rd_mux = ctl2;
            A_PINC:   rd_mux = pinc;
            A_WMASK:  rd_mux = wmask;
            A_TMASK:  rd_mux = tmask;
            A_TILTT:  rd_mux = tiltt;
            A_WAKET:  rd_mux = waket;
            A_TTH:    rd_mux = tap_high_threshold;
            A_TTL:    rd_mux = ttl;
            A_FALL_THRESHOLD_REGISTER:   rd_mux = fall_threshold_register;
            A_FFC:    rd_mux = ffc;
            A_FFCTL:  rd_mux = ffctl;
            default:  rd_mux = RST_ZERO;
        endcase
    endfunction : rd_mux

    // Read data loads after the address byte, shifts on falling edges
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            tx      <= '0;
            rd_rel  <= 1'b0;
        end
        else if (ce)
        begin
            rd_rel <= 1'b0;
            if (rise && ready && bcnt == 4'd7 && rx[6])
            begin
                tx     <= rd_mux({rx[5:0], s2[0]});
                rd_rel <= ({rx[5:0], s2[0]} == A_REL);
            end
            else if (fall)
                tx <= {tx[6:0], 1'b0};
        end

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            link.miso    <= 1'b0;
            link.miso_oe <= 1'b0;
        end
        else if (ce)
        begin
            link.miso_oe <= cs_act && ready;
            if (fall)
                link.miso <= tx[7];
        end

    always_ff @(posedge aclk)
        if (!aresetn || ce && srst_req)
        begin
            {ctl1, ctl2, pinc, wmask, tmask, tiltt} <= '0;
            {waket, tap_high_threshold, ttl, fall_threshold_register, ffc, ffctl} <= '0;
            srst_req <= 1'b0;
        end
        else if (ce && wr_done)
        begin
            unique case (frame[14:8])
                A_CTL1:  ctl1  <= frame[7:0];
                A_CTL2:
                begin
                    ctl2     <= frame[7:0];
                    srst_req <= frame[B_SRST];
                end
                A_PINC:  pinc  <= frame[7:0];
                A_WMASK: wmask <= frame[7:0];
                A_TMASK: tmask <= frame[7:0];
                A_TILTT: tiltt <= frame[7:0];
                A_WAKET: waket <= frame[7:0];
                A_TTH:   tap_high_threshold   <= frame[7:0];
                A_TTL:   ttl   <= frame[7:0];
                A_FALL_THRESHOLD_REGISTER:  fall_threshold_register  <= frame[7:0];
                A_FFC:   ffc   <= frame[7:0];
                A_FFCTL: ffctl <= frame[7:0];
                default: ;
            endcase
        end

    // Start-up delay after the operating bit is set
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            start_cnt   <= '0;
            accel_valid <= 1'b0;
        end
        else if (ce)
        begin
            if (!ctl1[B_OP])
            begin
                start_cnt   <= 22'(START_W);
                accel_valid <= 1'b0;
            end
            else if (start_cnt != '0)
                start_cnt <= start_cnt - 22'd1;
            else
                accel_valid <= 1'b1;
        end

    // ==========================================================
    // Engines; counters advance only on their own data-rate tick
    logic [5:0] tilt_cur, tilt_cand;
    logic [7:0] tilt_cnt, wake_cnt, fall_cnt;
    logic       ev_tilt, ev_wake, ev_tap, ev_fall;
    wire        run = ctl1[B_OP];

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            {tilt_cur, tilt_cand, tilt_cnt} <= '0;
            ev_tilt <= 1'b0;
        end
        else if (ce)
        begin
            ev_tilt <= 1'b0;
            if (run && ctl1[B_TPE] && tilt_tick)
            begin
                if (tilt_orient != tilt_cand)
                begin
                    tilt_cand <= tilt_orient;
                    tilt_cnt  <= '0;
                end
                else if (tilt_cnt < tiltt)
                    tilt_cnt <= tilt_cnt + 8'd1;
                else if (tilt_cand != tilt_cur)
                begin
                    tilt_cur <= tilt_cand;
                    ev_tilt  <= |(tilt_cand & ctl2[5:0]);
                end
            end
        end

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            wake_cnt <= '0;
            ev_wake  <= 1'b0;
        end
        else if (ce)
        begin
            ev_wake <= 1'b0;
            if (run && ctl1[B_WAKE_ENGINE_ENABLE] && wake_tick)
            begin
                if (!(|(wake_over & wmask[5:0])))
                    wake_cnt <= '0;
                else if (wake_cnt < waket)
                    wake_cnt <= wake_cnt + 8'd1;
                if (|(wake_over & wmask[5:0]) && wake_cnt + 8'd1 == waket)
                    ev_wake <= 1'b1;
            end
        end

    always_ff @(posedge aclk)
        if (!aresetn)
            ev_tap <= 1'b0;
        else if (ce)
            ev_tap <= run && ctl1[B_TAP_ENGINE_ENABLE] && tap_tick
                      && tap_jerk > ttl && tap_jerk < tap_high_threshold
                      && |(tap_dir & tmask[5:0]);

    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            fall_cnt <= '0;
            ev_fall  <= 1'b0;
        end
        else if (ce)
        begin
            ev_fall <= 1'b0;
            if (run && ffctl[B_FALL_ENGINE_ENABLE] && fall_tick)
            begin
                if (fall_mag >= fall_threshold_register)
                    fall_cnt <= '0;
                else if (fall_cnt <= ffc)
                begin
                    fall_cnt <= fall_cnt + 8'd1;
                    ev_fall  <= (fall_cnt == ffc);
                end
            end
        end

    // ==========================================================
    // Sources, pin shaping; an event beats a same-cycle release
    logic [8:0] pulse_cnt;
    wire  [7:0] ev_vec = {ev_fall, 4'h0, ev_tap, ev_wake, ev_tilt};
    always_ff @(posedge aclk)
        if (!aresetn || ce && srst_req)
            src2 <= '0;
        else if (ce)
            src2 <= (rd_rel ? 8'h00 : src2) | ev_vec;

    always_ff @(posedge aclk)
        if (!aresetn)
            pulse_cnt <= '0;
        else if (ce)
        begin
            if (|ev_vec)
                pulse_cnt <= 9'(PULSE_CYC);
            else if (pulse_cnt != '0)
                pulse_cnt <= pulse_cnt - 9'd1;
        end

    wire active = pinc[B_LATCH] ? (pulse_cnt != '0) : |src2;
    always_ff @(posedge aclk)
        if (!aresetn)
            link.int_pin <= 1'b1;
        else if (ce)
            link.int_pin <= (pinc[B_PEN] && active)
                            ~^ pinc[B_POL];
endmodule : aip_device
`default_nettype wire

/* File: rtl/aip_host.sv */
// Purpose: host end; AXI4-Lite orders become SPI frames to the sensor
// Assumes: sensor pins arrive asynchronously and are synchronised
// Notes:   commands are refused while a frame or a wait is under way
`timescale 1ns/100ps
`default_nettype none
module aip_host
    import aip_pkg::*;
#(
    parameter int BOOT_W = BOOT_MAX_CYC,
    parameter int SRST_W = SRST_CYC,
    parameter int MODE_W = 400_000,
    parameter int HALF   = SCK_HALF
)(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    aip_link_if.host         link
);
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_WAIT} aip_st_e;
    aip_st_e     st;
    logic [1:0]  m1, m2;
    logic [3:0]  aw_a;
    logic [15:0] cmd, sh, fcmd;
    logic [7:0]  rdat;
    logic [4:0]  nbit;
    logic [7:0]  hcnt;
    logic [24:0] wcnt;
    logic        aw_ok, w_ok, go, cmd_ok, op_was;

    // ==========================================================
    // Synchronisers for miso and the interrupt pin
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            m1 <= '0;
            m2 <= '0;
        end
        else if (ce)
        begin
            m1 <= {link.int_pin, link.miso};
            m2 <= m1;
        end

    // ==========================================================
    // AXI4-Lite write: address and data taken in either order
    wire busy = (st != H_IDLE) || go;
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            {s_axi_awready, s_axi_wready, s_axi_bvalid} <= '0;
            {aw_ok, w_ok, go, cmd_ok} <= '0;
            s_axi_bresp <= RESP_OK;
            aw_a <= '0;
            cmd  <= '0;
        end
        else if (ce)
        begin
            go <= 1'b0;
            s_axi_awready <= !aw_ok && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_ok && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok <= 1'b1;
                aw_a  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok <= 1'b1;
                cmd  <= s_axi_wdata[15:0];
            end
            if (aw_ok && w_ok && !s_axi_bvalid)
            begin
                aw_ok <= 1'b0;
                w_ok  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                cmd_ok <= (aw_a == H_CMD) && !busy;
                go     <= (aw_a == H_CMD) && !busy;
                s_axi_bresp <= (aw_a == H_CMD) && !busy ? RESP_OK : RESP_ERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end

    // AXI4-Lite read: status word
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            {s_axi_arready, s_axi_rvalid} <= '0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OK;
        end
        else if (ce)
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= (s_axi_araddr == H_STATUS) ? RESP_OK : RESP_ERR;
                s_axi_rdata  <= {16'h0, rdat, 5'h0, cmd_ok, m2[1], busy};
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end

    // ==========================================================
    // Frame engine; sclk period 2*HALF clocks stays under 10 MHz
    wire srst_sent = fcmd[14:8] == A_CTL2 && !fcmd[15] && fcmd[B_SRST];
    wire op_rise = fcmd[14:8] == A_CTL1 && !fcmd[15] && fcmd[B_OP] && !op_was;
    always_ff @(posedge aclk)
        if (!aresetn)
        begin
            st <= H_WAIT;
            wcnt <= 25'(BOOT_W);
            {link.sclk, link.mosi} <= '0;
            link.cs_n <= 1'b1;
            {sh, fcmd, rdat, nbit, hcnt, op_was} <= '0;
        end
        else if (ce)
        begin
            unique case (st)
                H_IDLE:
                    if (go)
                    begin
                        st <= H_LOW;
                        link.cs_n <= 1'b0;
                        link.mosi <= cmd[15];
                        sh <= {cmd[14:0], 1'b0};
                        fcmd <= cmd;
                        nbit <= '0;
                        hcnt <= 8'(HALF);
                    end
                H_LOW:
                    if (hcnt > 8'd1)
                        hcnt <= hcnt - 8'd1;
                    else
                    begin
                        link.sclk <= 1'b1;
                        hcnt <= 8'(HALF);
                        st <= H_HIGH;
                    end
                H_HIGH:
                    if (hcnt > 8'd1)
                        hcnt <= hcnt - 8'd1;
                    else
                    begin
                        link.sclk <= 1'b0;
                        hcnt <= 8'(HALF);
                        if (nbit >= 5'd8)
                            rdat <= {rdat[6:0], m2[0]};
                        nbit <= nbit + 5'd1;
                        link.mosi <= sh[15];
                        sh <= {sh[14:0], 1'b0};
                        st <= H_LOW;
                        if (nbit == 5'(FRAME_BITS - 1))
                        begin
                            link.cs_n <= 1'b1;
                            st <= H_WAIT;
                            if (fcmd[14:8] == A_CTL1 && !fcmd[15])
                                op_was <= fcmd[B_OP];
                            if (srst_sent) op_was <= 1'b0;
                            if (srst_sent)
                                wcnt <= 25'(SRST_W);
                            else if (op_rise)
                                wcnt <= 25'(MODE_W);
                            else
                                wcnt <= 25'(HALF);
                        end
                    end
                H_WAIT:
                    if (wcnt > 25'd1)
                        wcnt <= wcnt - 25'd1;
                    else
                        st <= H_IDLE;
            endcase
        end
endmodule : aip_host
`default_nettype wire

/* File: bench/aip_link_monitor.sv */
// Purpose: watches the SPI link and interrupt pin between both ends
// Assumes: host half period of 8 clocks, 16-bit frames
// Notes:   one clock domain, so default clocking is used
`timescale 1ns/100ps
`default_nettype none
module aip_link_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic int_pin
);
    // ==========================================================
    // Link shape
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_sck_hi; $rose(sclk) |=> sclk [*7]; endproperty
    a_sck_hi: assert property (p_sck_hi)
        else $error("serial clock high phase too short");
    property p_sck_lo; $fell(sclk) && !cs_n |=> !sclk [*7]; endproperty
    a_sck_lo: assert property (p_sck_lo)
        else $error("serial clock low phase too short");
    property p_idle; cs_n |-> !sclk; endproperty
    a_idle: assert property (p_idle)
        else $error("serial clock not idle low");
    property p_lead; $fell(cs_n) |=> !sclk [*7]; endproperty
    a_lead: assert property (p_lead)
        else $error("select to first clock edge too short");
    property p_mosi; !cs_n && sclk |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi)
        else $error("data moved while clock high");
    property p_frame; $fell(cs_n) |-> ##[250:275] $rose(cs_n); endproperty
    a_frame: assert property (p_frame)
        else $error("frame length wrong");
    property p_gap; $rose(cs_n) |=> cs_n [*7]; endproperty
    a_gap: assert property (p_gap)
        else $error("frames too close");
    // A pin glitch shorter than 8 clocks would be lost by a slow host
    property p_pin; $changed(int_pin) |=> $stable(int_pin) [*8]; endproperty
    a_pin: assert property (p_pin)
        else $error("interrupt pin glitch");
endmodule : aip_link_monitor
`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: drives the host over AXI4-Lite, the device through its engines
// Assumes: shortened boot, reset and mode waits
// Notes:   fall and tap engines stirred; tilt, wake quiet
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import aip_pkg::*;
    logic        aclk = 0, aresetn = 0, ce = 1;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, accel_valid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        tilt_tick = 0, wake_tick = 0, tap_tick = 0, fall_tick = 0;
    logic [5:0]  tilt_orient = 0, wake_over = 0, tap_dir = 0;
    logic [7:0]  tap_jerk = 0, fall_mag = 0;
    logic [31:0] d;
    int          fail_count = 0, checks_done = 0, n;
    aip_link_if lk();
    aip_host #(.BOOT_W(300), .SRST_W(100), .MODE_W(50)) u_aip_host
        (.*, .link(lk));
    aip_device #(.BOOT_CYC(200), .SRST_W(100), .START_W(50)) u_aip_device
        (.*, .link(lk));
    aip_link_monitor u_aip_link_monitor (.aclk(aclk), .aresetn(aresetn),
        .sclk(lk.sclk), .cs_n(lk.cs_n), .mosi(lk.mosi),
        .int_pin(lk.int_pin));
    initial forever #50 aclk = ~aclk;
    // ==========================================================
    // Checking and bus tasks
    task results;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task ck(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : ck
    task tmo;
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
        results;
    endtask : tmo
    task axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] o);
        int i;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 200; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (i == 200) tmo;
        o = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw
    task axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] o);
        int i;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 200; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (i == 200) tmo;
        v = s_axi_rdata;
        o = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr
    task idle;
        int i;
        for (i = 0; i < 2000; i++)
        begin
            axr(H_STATUS, d, r);
            if (d[0] === 1'b0) break;
        end
        if (i == 2000) tmo;
    endtask : idle
    task dw(input logic [6:0] a, input logic [7:0] v);
        axw(H_CMD, {16'h0000, 1'b0, a, v}, r);
        ck(16'(r), 16'(RESP_OK));
        idle;
    endtask : dw
    task dr(input logic [6:0] a, input logic [7:0] e);
        axw(H_CMD, {16'h0000, 1'b1, a, 8'h00}, r);
        idle;
        ck(16'(d[15:8]), 16'(e));
    endtask : dr
    // Two resetting ticks, then four quiet ones: the count reaches 3
    task trig(input logic act, output int c);
        int i;
        c = 0;
        for (i = 0; i < 1000; i++)
        begin
            @(posedge aclk);
            fall_tick <= (i % 10 == 5) && (i < 60);
            fall_mag  <= (i < 20) ? 8'hff : 8'h00;
            if (lk.int_pin === act) c++;
        end
    endtask : trig
    // ==========================================================
    // Tests
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        idle;
        axw(4'h8, 32'h0, r);
        ck(16'(r), 16'(RESP_ERR));
        axr(4'h8, d, r);
        ck(16'(r), 16'(RESP_ERR));
        axw(H_CMD, {16'h0000, 1'b1, A_SRC2, 8'h00}, r);
        axw(H_CMD, 32'h0, r);
        ck(16'(r), 16'(RESP_ERR));
        idle;
        $display("refusal test done");
        dw(A_FALL_THRESHOLD_REGISTER, 8'h02);
        dw(A_FFC, 8'h02);
        dw(A_FFCTL, 8'h80);
        dw(A_PINC, 8'h30);
        dw(A_CTL1, 8'h80);
        ck(lk.int_pin, 1'b0);
        trig(1'b1, n);
        ck(lk.int_pin, 1'b1);
        dr(A_STATUS, 8'h11);
        dr(A_SRC2, 8'h80);
        dr(A_REL, 8'h00);
        ck(lk.int_pin, 1'b0);
        dr(A_SRC2, 8'h00);
        dr(A_STATUS, 8'h01);
        $display("latched test done");
        dw(A_PINC, 8'h10);
        trig(1'b1, n);
        ck(16'(n), 16'h0000);
        dr(A_REL, 8'h00);
        dw(A_PINC, 8'h20);
        ck(lk.int_pin, 1'b1);
        $display("enable and polarity test done");
        dw(A_PINC, 8'h28);
        trig(1'b0, n);
        ck(16'(n), 16'(PULSE_CYC));
        ck(lk.int_pin, 1'b1);
        dr(A_SRC2, 8'h80);
        dr(A_REL, 8'h00);
        dw(A_PINC, 8'h30);
        ce <= 1'b0;
        trig(1'b1, n);
        ce <= 1'b1;
        ck(16'(n), 16'h0000);
        dw(A_FFCTL, 8'h00);
        trig(1'b1, n);
        ck(16'(n), 16'h0000);
        dw(A_TTH, 8'h06);
        dw(A_TMASK, 8'h01);
        dw(A_CTL1, 8'h84);
        tap_jerk <= 8'h05;
        tap_dir  <= 6'h01;
        tap_tick <= 1'b1;
        @(posedge aclk);
        tap_tick <= 1'b0;
        dr(A_SRC2, 8'h04);
        $display("pulse and engine enable test done");
        results;
    end
endmodule : testbench
`default_nettype wire
